// File: src/roc_rail_channel.sv
// One rail: debounce, latch and control byte of over-current handling
`timescale 1ns/10ps
`default_nettype none
`include "roc_regs.svh"

module roc_rail_channel (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_sync_b_i,
  // Control byte write
  input wire logic ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  // Analog indications
  input wire roc_pkg::roc_rail_in_t rail_i,
  // Results
  output roc_pkg::roc_ctrl_t ctrl_o,
  output logic [7:0] status_o,
  output logic oc_event_o,
  output logic shutdown_o
);

  roc_pkg::roc_ctrl_t ctrl; // Control byte
  roc_pkg::roc_deb_state_t deb_state; // Debounce state
  logic [`ROC_DEB_CNT_W-1:0] deb_cnt; // Cycles comparator held high
  logic [`ROC_DEB_CNT_W-1:0] deb_limit; // Selected debounce length
  logic oc_latched; // Sticky over-current
  logic clear_armed; // Flag-clear bit seen at zero
  logic trip; // Debounce completed this cycle
  logic auto_off; // Held shutdown request
  logic [`ROC_DEB_CNT_W-1:0] hold_cnt; // Checker: edges comparator held

  // Control byte register
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_i) begin
    if (!rst_sync_b_i) begin
      ctrl <= roc_pkg::roc_ctrl_t'(`ROC_CTRL_RESET);
    end else if (ctrl_wr_i) begin
      ctrl <= roc_pkg::roc_ctrl_t'(ctrl_wdata_i);
    end
  end

  // Debounce length from selector
  always_comb begin
    unique case (ctrl.debounce_sel)
      2'b00: deb_limit = `ROC_DEB_CNT_W'(`ROC_DEB_120_CYC);
      2'b01: deb_limit = `ROC_DEB_CNT_W'(`ROC_DEB_240_CYC);
      2'b10: deb_limit = `ROC_DEB_CNT_W'(`ROC_DEB_480_CYC);
      2'b11: deb_limit = `ROC_DEB_CNT_W'(`ROC_DEB_960_CYC);
    endcase
  end

  assign trip = (deb_state == roc_pkg::ROC_COUNTING) && rail_i.overcurrent
                && ctrl.protect_enable && (deb_cnt >= deb_limit - 1'b1);

  // Debounce machine; any drop restarts the count
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_i) begin
    if (!rst_sync_b_i) begin
      deb_state <= roc_pkg::ROC_IDLE;
      deb_cnt <= '0;
    end else if (!rail_i.overcurrent || !ctrl.protect_enable) begin
      deb_state <= roc_pkg::ROC_IDLE;
      deb_cnt <= '0;
    end else begin
      unique case (deb_state)
        roc_pkg::ROC_IDLE: begin
          deb_state <= roc_pkg::ROC_COUNTING;
          deb_cnt <= `ROC_DEB_CNT_W'(1);
        end
        roc_pkg::ROC_COUNTING: begin
          // Held for the full time: trip once
          if (trip) begin
            deb_state <= roc_pkg::ROC_TRIPPED;
          end else begin
            deb_cnt <= deb_cnt + 1'b1;
          end
        end
        roc_pkg::ROC_TRIPPED: begin
          deb_state <= roc_pkg::ROC_TRIPPED;
        end
        // Unused code falls back to idle
        default: begin
          deb_state <= roc_pkg::ROC_IDLE;
        end
      endcase
    end
  end

  // Re-arm tracks the flag-clear bit returning to zero
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_i) begin
    if (!rst_sync_b_i) begin
      clear_armed <= 1'b1;
    end else begin
      clear_armed <= !ctrl.flag_clear;
    end
  end

  // Sticky latch; clear wins over trip, which sets it only when armed
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_i) begin
    if (!rst_sync_b_i) begin
      oc_latched <= 1'b0;
    end else if (trip && clear_armed && !ctrl.flag_clear) begin
      oc_latched <= 1'b1;
    end else if (ctrl.flag_clear) begin
      oc_latched <= 1'b0;
    end
  end

  // Shutdown held until protection or auto-off is turned off
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_i) begin
    if (!rst_sync_b_i) begin
      auto_off <= 1'b0;
    end else if (!ctrl.auto_off_enable || !ctrl.protect_enable) begin
      auto_off <= 1'b0;
    end else if (trip) begin
      auto_off <= 1'b1;
    end
  end

  assign shutdown_o = auto_off;
  assign oc_event_o = trip && ctrl.irq_forward_enable;
  assign ctrl_o = ctrl;

  // Status byte assembly
  always_comb begin
    status_o = 8'h00;
    status_o[`ROC_STAT_INPUT_GOOD_BIT] = rail_i.rail_enabled
                                         && rail_i.input_good;
    // Disabled rail reads ramp not done, so idle byte is the reset value
    status_o[`ROC_STAT_RAMP_DONE_BIT] = rail_i.rail_enabled
                                        && !rail_i.ramping;
    status_o[`ROC_STAT_OC_LATCHED_BIT] = oc_latched;
    // Fault only outside a ramp; a ramp in progress reads clean
    status_o[`ROC_STAT_REG_FAULT_BIT] = !rail_i.ramping
                                        && !rail_i.output_good;
    status_o[`ROC_STAT_SETTLED_BIT] = !rail_i.ramping
                                      && rail_i.output_good;
  end

  // Checker helper: consecutive edges with comparator high, protection on
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_i) begin
    if (!rst_sync_b_i) begin
      hold_cnt <= '0;
    end else if (!rail_i.overcurrent || !ctrl.protect_enable) begin
      hold_cnt <= '0;
    end else if (hold_cnt != '1) begin
      hold_cnt <= hold_cnt + 1'b1;
    end
  end

  // Armed trip: debounce done, latch re-armed, clear bit low
  sequence armed_trip_s;
    trip && clear_armed && !ctrl.flag_clear;
  endsequence

  // Latch is set the cycle after an armed trip
  latch_sets_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b_i)
    armed_trip_s |=> oc_latched)
    else $error("latch did not set on trip");

  // Latch rises only after an armed trip
  re_arm_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b_i)
    $rose(oc_latched) |-> $past(trip && clear_armed && !ctrl.flag_clear))
    else $error("latch set while not armed");

  // Latch stays set until the clear bit is written
  latch_sticky_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b_i)
    oc_latched && !ctrl.flag_clear |=> oc_latched)
    else $error("latch dropped without clear");

  // Clear bit drops the latch the next cycle
  flag_clear_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b_i)
    ctrl.flag_clear |=> !oc_latched)
    else $error("flag clear left latch set");

  // No trip with protection off
  protect_gate_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b_i)
    !ctrl.protect_enable |-> !trip && !oc_event_o)
    else $error("trip while protection disabled");

  // Trip needs the comparator held for the selected time
  debounce_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b_i)
    trip |-> rail_i.overcurrent && hold_cnt >= deb_limit - 1'b1)
    else $error("trip without held comparator");

  // Forwarded event only when enabled
  irq_forward_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b_i)
    trip |-> oc_event_o == ctrl.irq_forward_enable)
    else $error("forwarding mismatch");

  // Auto-off follows a trip
  auto_off_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b_i)
    trip && ctrl.auto_off_enable |=> shutdown_o || !ctrl.auto_off_enable)
    else $error("no shutdown after trip");

endmodule : roc_rail_channel
`default_nettype wire

// File: shared/roc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ROC_REGS_SVH
`define ROC_REGS_SVH

// Register offsets (byte addresses on the serial register bus)
`define ROC_RAIL2_CTRL_ADDR 8'h13
`define ROC_RAIL3_STATUS_ADDR 8'h14
`define ROC_RAIL3_CTRL_ADDR 8'h15
`define ROC_RAIL4_STATUS_ADDR 8'h16
`define ROC_RAIL4_CTRL_ADDR 8'h17
`define ROC_RAIL5_STATUS_ADDR 8'h18
`define ROC_RAIL5_CTRL_ADDR 8'h19
`define ROC_RAIL6_STATUS_ADDR 8'h1A
`define ROC_RAIL6_CTRL_ADDR 8'h1B
// First status address of the rail 3 to 6 pairs
`define ROC_PAIR_BASE_ADDR 8'h14

// Reset values
`define ROC_CTRL_RESET 8'hC0
`define ROC_STATUS_RESET 8'h40

// Control byte fields
`define ROC_CTRL_FLAG_CLEAR_BIT 1
`define ROC_CTRL_IRQ_FWD_BIT 2
`define ROC_CTRL_DEB_LSB 4
`define ROC_CTRL_AUTO_OFF_BIT 6
`define ROC_CTRL_PROTECT_BIT 7

// Status byte fields
`define ROC_STAT_INPUT_GOOD_BIT 0
`define ROC_STAT_RAMP_DONE_BIT 2
`define ROC_STAT_OC_LATCHED_BIT 5
`define ROC_STAT_REG_FAULT_BIT 6
`define ROC_STAT_SETTLED_BIT 7

// Clock rate and debounce times
`define ROC_CLK_HZ 25000000
`define ROC_DEB_120_US 120
`define ROC_DEB_240_US 240
`define ROC_DEB_480_US 480
`define ROC_DEB_960_US 960
`define ROC_US_CYCLES(us) ((us) * (`ROC_CLK_HZ / 1000000))
`define ROC_DEB_120_CYC `ROC_US_CYCLES(`ROC_DEB_120_US)
`define ROC_DEB_240_CYC `ROC_US_CYCLES(`ROC_DEB_240_US)
`define ROC_DEB_480_CYC `ROC_US_CYCLES(`ROC_DEB_480_US)
`define ROC_DEB_960_CYC `ROC_US_CYCLES(`ROC_DEB_960_US)

// Number of channels and counter width
`define ROC_NUM_RAILS 5
`define ROC_DEB_CNT_W 15

`endif

// File: shared/roc_pkg.sv
// Types shared by the rail over-current register bank
package roc_pkg;

  // Control byte layout
  typedef struct packed {
    logic protect_enable;
    logic auto_off_enable;
    logic [1:0] debounce_sel;
    logic unused3;
    logic irq_forward_enable;
    logic flag_clear;
    logic reserved0;
  } roc_ctrl_t;

  // Analog indications of one rail
  typedef struct packed {
    logic rail_enabled;
    logic input_good;
    logic ramping;
    logic output_good;
    logic overcurrent;
  } roc_rail_in_t;

  // Register bus request
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } roc_bus_req_t;

  // Debounce machine states
  typedef enum logic [1:0] {
    ROC_IDLE,
    ROC_COUNTING,
    ROC_TRIPPED
  } roc_deb_state_t;

endpackage : roc_pkg

// File: src/roc_regbank.sv
// Status registers for rails 3 to 6 and over-current control registers for rails 2 to 6
`timescale 1ns/10ps
`default_nettype none
`include "roc_regs.svh"

module roc_regbank (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Register access from the serial bus engine
  input wire roc_pkg::roc_bus_req_t bus_req_i,
  output logic [7:0] bus_rdata_o,
  output logic bus_hit_o,
  // Rail indications, index 0 is rail 2
  input wire logic [4:0] rail_enabled_i,
  input wire logic rail2_input_good_i,
  input wire logic shared_input_good_i,
  input wire logic rail5_input_good_i,
  input wire logic rail6_input_good_i,
  input wire logic [4:0] ramping_i,
  input wire logic [4:0] output_good_compare_i,
  input wire logic [4:0] overcurrent_i,
  // Global latch clear and outputs
  input wire logic global_overcurrent_latch_clear_i,
  output logic global_overcurrent_latched_o,
  output logic [4:0] rail_shutdown_o,
  output logic [4:0] overcurrent_protect_enable_o
);

  logic rst_meta_b; // First reset stage
  logic rst_sync_b; // Released reset
  logic [4:0] in_good; // Input good per rail
  logic [4:0] ctrl_wr; // Control write strobes
  logic [4:0] oc_event; // Forwarded events
  logic [7:0] status [5]; // Status bytes
  roc_pkg::roc_ctrl_t ctrl [5]; // Control bytes
  logic [7:0] rdata; // Next read data
  logic hit; // Address decoded
  logic [7:0] rel; // Offset from pair base
  logic global_latched; // Global latch

  // Reset release through two flops
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // Input good fan-out; rails 3 and 4 see one supply
  assign in_good = {rail6_input_good_i, rail5_input_good_i,
                    shared_input_good_i, shared_input_good_i,
                    rail2_input_good_i};

  // Address decode: status even, control odd
  assign rel = bus_req_i.addr - `ROC_PAIR_BASE_ADDR;
  always_comb begin
    ctrl_wr = '0;
    if (bus_req_i.wr_en && bus_req_i.addr == `ROC_RAIL2_CTRL_ADDR) begin
      ctrl_wr[0] = 1'b1;
    end
    for (int i = 1; i < `ROC_NUM_RAILS; i++) begin
      if (bus_req_i.wr_en && bus_req_i.addr >= `ROC_PAIR_BASE_ADDR
          && rel[7:1] == 7'(i - 1) && rel[0]) begin
        ctrl_wr[i] = 1'b1; // status writes ignored
      end
    end
  end

  // Channel instances
  for (genvar g = 0; g < `ROC_NUM_RAILS; g++) begin : g_rail
    roc_rail_channel u_chan (
      .sys_clk_i(sys_clk_i),
      .rst_sync_b_i(rst_sync_b),
      .ctrl_wr_i(ctrl_wr[g]),
      .ctrl_wdata_i(bus_req_i.wdata),
      .rail_i({rail_enabled_i[g], in_good[g], ramping_i[g],
               output_good_compare_i[g], overcurrent_i[g]}),
      .ctrl_o(ctrl[g]),
      .status_o(status[g]),
      .oc_event_o(oc_event[g]),
      .shutdown_o(rail_shutdown_o[g])
    );
    assign overcurrent_protect_enable_o[g] = ctrl[g].protect_enable;
  end

  // Read mux
  always_comb begin
    rdata = 8'h00;
    hit = 1'b0;
    if (bus_req_i.addr == `ROC_RAIL2_CTRL_ADDR) begin
      rdata = ctrl[0];
      hit = 1'b1;
    end
    for (int i = 1; i < `ROC_NUM_RAILS; i++) begin
      if (bus_req_i.addr >= `ROC_PAIR_BASE_ADDR && rel[7:1] == 7'(i - 1)) begin
        rdata = rel[0] ? 8'(ctrl[i]) : status[i];
        hit = 1'b1;
      end
    end
  end

  // Registered read data
  always_ff @(posedge sys_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bus_rdata_o <= 8'h00;
      bus_hit_o <= 1'b0;
    end else if (bus_req_i.rd_en) begin
      bus_rdata_o <= rdata;
      bus_hit_o <= hit;
    end
  end

  // Global latch; a new event wins over the clear
  always_ff @(posedge sys_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      global_latched <= 1'b0;
    end else if (|oc_event) begin
      global_latched <= 1'b1;
    end else if (global_overcurrent_latch_clear_i) begin
      global_latched <= 1'b0;
    end
  end
  assign global_overcurrent_latched_o = global_latched;

  // Any forwarded event sets the global latch
  global_set_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b)
    |oc_event |=> global_overcurrent_latched_o)
    else $error("global latch missed event");

  // Global latch stays set until the clear input is seen
  global_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b)
    global_overcurrent_latched_o && !global_overcurrent_latch_clear_i
    |=> global_overcurrent_latched_o)
    else $error("global latch dropped without clear");

  // Global latch rises only on a forwarded event
  global_rise_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b)
    $rose(global_overcurrent_latched_o) |-> $past(|oc_event))
    else $error("global latch set without event");

  // Shared supply reads alike on rails 3 and 4
  shared_input_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b)
    rail_enabled_i[1] && rail_enabled_i[2]
    |-> status[1][0] == status[2][0])
    else $error("shared input good differs");

  // Read of rail 3 status returns its byte
  status_read_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b)
    bus_req_i.rd_en && bus_req_i.addr == `ROC_RAIL3_STATUS_ADDR
    |=> bus_hit_o && bus_rdata_o == $past(status[1]))
    else $error("status read wrong");

  // Rail 2 control byte reads back at its odd address
  rail2_read_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b)
    bus_req_i.rd_en && bus_req_i.addr == `ROC_RAIL2_CTRL_ADDR
    |=> bus_hit_o && bus_rdata_o == $past(8'(ctrl[0])))
    else $error("rail 2 control read wrong");

  // Unmapped reads answer zero with no hit
  unmapped_read_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b)
    bus_req_i.rd_en && (bus_req_i.addr < `ROC_RAIL2_CTRL_ADDR
    || bus_req_i.addr > `ROC_RAIL6_CTRL_ADDR)
    |=> !bus_hit_o && bus_rdata_o == 8'h00)
    else $error("unmapped read answered");

  // Control write to rail 3 lands the next cycle
  ctrl_write_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b)
    bus_req_i.wr_en && bus_req_i.addr == `ROC_RAIL3_CTRL_ADDR
    |=> 8'(ctrl[1]) == $past(bus_req_i.wdata))
    else $error("control write lost");

  // Even (status) addresses never strobe a control byte
  status_ro_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_b)
    bus_req_i.addr[0] == 1'b0 |-> ctrl_wr == 5'h00)
    else $error("status write reached control");

endmodule : roc_regbank
`default_nettype wire

// File: verification/roc_host_model.sv
// Host controller model driving the rail bank register bus
`timescale 1ns/10ps
`default_nettype none

module roc_host_model (
  // Clock
  input wire logic sys_clk_i,
  // Bus request and global latch clear
  output roc_pkg::roc_bus_req_t bus_req_o,
  output logic glob_clr_o
);
  logic [8:0] exp_q[$]; // Expected hit and data of each read

  // Quiet bus at time zero
  initial begin
    bus_req_o = '0;
    glob_clr_o = 1'b0;
  end

  // One access held for one edge; released fields are inverted
  task automatic cyc(input logic wr_i, input logic [7:0] a, d);
    @(posedge sys_clk_i);
    bus_req_o <= '{wr_en: wr_i, rd_en: !wr_i, addr: a, wdata: d};
    @(posedge sys_clk_i);
    bus_req_o <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
  endtask : cyc

  // Read with its expected answer noted first
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    cyc(1'b0, a, 8'h00);
  endtask : rd

  // Write with the reserved bit always sent as zero
  task automatic wr(input logic [7:0] a, d);
    cyc(1'b1, a, d & 8'hFE);
  endtask : wr

  // Clear a rail latch, then write the bit back to re-arm
  task automatic clr(input logic [7:0] a, c);
    wr(a, c | 8'h02);
    wr(a, c & 8'hFD);
  endtask : clr

  // Global clear held across the rail clear
  task automatic gclr(input logic [7:0] a, c);
    @(posedge sys_clk_i);
    glob_clr_o <= 1'b1;
    clr(a, c);
    glob_clr_o <= 1'b0;
  endtask : gclr
endmodule : roc_host_model
`default_nettype wire

// File: verification/roc_regbank_tb.sv
// Self-checking bench for the rail over-current register bank
`timescale 1ns/10ps
`default_nettype none
`include "roc_regs.svh"

module roc_regbank_tb;
  logic sys_clk_i; // 25 MHz clock
  logic rst_b_i; // Active-low reset
  roc_pkg::roc_bus_req_t bus_req; // Host request
  logic [7:0] rdata; // Read data
  logic hit; // Mapped read flag
  logic [4:0] en, ramp, ogood, oc; // Rail indications
  logic [3:0] good; // Input good: rail2, shared, rail5, rail6
  logic glob_clr; // Global latch clear
  logic glob; // Global latch
  logic [4:0] shut, prot; // Shutdown and protect enables
  logic rd_pend; // Read answer due at this edge
  int miscompares; // Mismatch count
  int tests_run; // Comparison count

  // Design and host
  roc_regbank u_dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus_req_i(bus_req),
    .bus_rdata_o(rdata), .bus_hit_o(hit), .rail_enabled_i(en),
    .rail2_input_good_i(good[0]), .shared_input_good_i(good[1]),
    .rail5_input_good_i(good[2]), .rail6_input_good_i(good[3]),
    .ramping_i(ramp), .output_good_compare_i(ogood),
    .overcurrent_i(oc), .global_overcurrent_latch_clear_i(glob_clr),
    .global_overcurrent_latched_o(glob), .rail_shutdown_o(shut),
    .overcurrent_protect_enable_o(prot)
  );
  roc_host_model u_host (
    .sys_clk_i(sys_clk_i), .bus_req_o(bus_req), .glob_clr_o(glob_clr)
  );

  // Clock generator
  always #20 sys_clk_i = ~sys_clk_i;

  // Verdict and end of run
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // One comparison
  task automatic chk(input logic [8:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got,
               exp);
    end
  endtask : chk

  // Expected status of rail r (1..4) with latch state l
  function automatic logic [8:0] stat(input int r, input logic l);
    logic g;
    g = (r < 3) ? good[1] : good[r - 1];
    return {1'b1, ~ramp[r] & ogood[r], ~ramp[r] & ~ogood[r], l, 2'b00,
            en[r] & ~ramp[r], 1'b0, en[r] & g};
  endfunction : stat

  // Read answers compared against the oldest note
  always @(posedge sys_clk_i) begin
    if (rd_pend && u_host.exp_q.size() > 0) begin
      chk({hit, rdata}, u_host.exp_q.pop_front());
    end
    rd_pend <= bus_req.rd_en;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    miscompares++;
    complete_run();
  end

  // Main sequence
  initial begin
    logic [7:0] c [5];
    logic [7:0] sa, ctl;
    logic [4:0] pe;
    int n;
    sys_clk_i = 1'b0;
    rst_b_i = 1'b0;
    rd_pend = 1'b0;
    {en, ramp, ogood, oc, good} = '0;
    void'($urandom(32'hBF07));
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    // Reset values, address map and unmapped places
    for (int a = 8'h12; a <= 8'h1C; a++) begin
      u_host.rd(8'(a), (a < 8'h13 || a > 8'h1B) ? 9'h000 :
                a[0] ? 9'h1C0 : 9'h140);
    end
    chk({prot, glob, shut[3:1]}, 9'h1F0);
    $display("Test reset and map done");
    // Status is read-only, control bytes read back
    u_host.wr(8'h14, 8'hFF);
    u_host.rd(8'h14, 9'h140);
    for (int r = 0; r < 5; r++) begin
      c[r] = 8'($urandom) & 8'hF4;
      pe[r] = c[r][7];
      u_host.wr(8'(8'h13 + 2 * r), c[r]);
    end
    for (int r = 0; r < 5; r++) begin
      u_host.rd(8'(8'h13 + 2 * r), {1'b1, c[r]});
    end
    chk({4'h0, prot}, {4'h0, pe});
    $display("Test access done");
    // Status fields follow the rail indications
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk_i);
      {en, ramp, ogood} <= 15'($urandom);
      good <= 4'($urandom);
      repeat (4) @(posedge sys_clk_i);
      for (int r = 1; r < 5; r++) begin
        u_host.rd(8'(8'h12 + 2 * r), stat(r, 1'b0));
      end
    end
    $display("Test status fields done");
    // Every debounce time, with forward and auto-off mixed
    @(posedge sys_clk_i);
    {en, ramp, ogood, good} <= {5'h1F, 5'h00, 5'h1F, 4'hF};
    for (int k = 0; k < 4; k++) begin
      sa = 8'(8'h14 + 2 * k);
      ctl = {1'b1, k[1], k[1:0], 1'b0, k[0], 2'b00};
      n = `ROC_DEB_120_CYC << k;
      u_host.gclr(sa + 8'h01, ctl);
      @(posedge sys_clk_i);
      oc[k + 1] <= 1'b1;
      repeat (n - 20) @(posedge sys_clk_i);
      u_host.rd(sa, 9'h185);
      repeat (30) @(posedge sys_clk_i);
      u_host.rd(sa, 9'h1A5);
      chk({7'h00, shut[k + 1], glob}, {7'h00, k[1], k[0]});
      oc[k + 1] <= 1'b0;
      u_host.clr(sa + 8'h01, ctl);
      u_host.rd(sa, 9'h185);
    end
    $display("Test debounce done");
    // Protection off blocks latch, shutdown and forwarding
    u_host.gclr(8'h15, 8'h44);
    @(posedge sys_clk_i);
    oc[1] <= 1'b1;
    repeat (`ROC_DEB_120_CYC + 100) @(posedge sys_clk_i);
    u_host.rd(8'h14, 9'h185);
    chk({7'h00, shut[1], glob}, 9'h000);
    oc[1] <= 1'b0;
    $display("Test protection off done");
    // No latch while clear is held; a dropout restarts the count
    u_host.wr(8'h15, 8'hC2);
    oc[1] <= 1'b1;
    repeat (`ROC_DEB_120_CYC + 100) @(posedge sys_clk_i);
    u_host.rd(8'h14, 9'h185);
    oc[1] <= 1'b0;
    u_host.wr(8'h15, 8'hC0);
    oc[1] <= 1'b1;
    repeat (`ROC_DEB_120_CYC - 100) @(posedge sys_clk_i);
    oc[1] <= 1'b0;
    @(posedge sys_clk_i);
    oc[1] <= 1'b1;
    repeat (`ROC_DEB_120_CYC - 100) @(posedge sys_clk_i);
    u_host.rd(8'h14, 9'h185);
    repeat (200) @(posedge sys_clk_i);
    u_host.rd(8'h14, 9'h1A5);
    oc[1] <= 1'b0;
    $display("Test re-arm and restart done");
    // Mid-run reset clears latch and shutdown, restores control bytes
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    chk({prot, shut[3:0]}, 9'h1F0);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    u_host.rd(8'h14, 9'h185);
    u_host.rd(8'h17, 9'h1C0);
    $display("Test mid-run reset done");
    repeat (4) @(posedge sys_clk_i);
    chk(9'(u_host.exp_q.size()), 9'h000);
    complete_run();
  end
endmodule : roc_regbank_tb
`default_nettype wire
